// *** src/fan_monitor_defines.vh ***
// Constants for the fan speed monitor and alarm block
`ifndef FAN_MONITOR_DEFINES_VH
`define FAN_MONITOR_DEFINES_VH

// Tick rate of the PWM time base, in Hz
`define TICK_HZ 25000
// Fan maximum speed, in RPM
`define MAX_ROTOR_SPEED 3300
// Full-scale code of the speed value
`define FULL_SCALE 255
// RPM to pulses per second, two pulses per revolution
`define RPM_TO_PPS 30
// Conversion constant for the speed divider
`define SPEED_K (`TICK_HZ * `FULL_SCALE * `RPM_TO_PPS / `MAX_ROTOR_SPEED)
// Alarm threshold as a percentage of the commanded speed
`define ALARM_PCT 8'h41
`define PCT_FULL 16'h0064

// Widths
`define PERIOD_W 16
`define QUOT_W 24
`define SPEED_W 8

// Default limits and start timing; lock limit, start delay and ramp interval in PWM ticks
`define LOCK_MAX_DEF 16'h1388
`define ALARM_MAX_DEF 8'h20
`define START_DELAY_DEF 16'h61a8
`define RAMP_STEP_DEF 8'h04
`define RAMP_INTERVAL_DEF 16'h00fa

// Start sequence states
`define ST_IDLE 2'h0
`define ST_DELAY 2'h1
`define ST_RAMP 2'h2
`define ST_RUN 2'h3

`endif

// *** src/speed_divider.v ***
// Sequential restoring divider for the speed conversion
`timescale 1ns/1ps

module speed_divider #(
  parameter NW = 24,
  parameter DW = 16
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [NW-1:0] dividend,
  input wire [DW-1:0] divisor,
  output reg [NW-1:0] quotient,
  output reg done
);

  reg [NW-1:0] num_r;
  reg [DW:0] rem_r;
  reg [DW-1:0] den_r;
  reg [5:0] cnt_r;
  reg busy_r;
  wire [DW:0] shifted;
  wire [DW:0] diff;

  assign shifted = {rem_r[DW-1:0], num_r[NW-1]};
  assign diff = shifted - {1'b0, den_r};

  // One quotient bit per clock, MSB first
  always @(posedge clk) begin
    if (rst) begin
      num_r <= {NW{1'b0}};
      rem_r <= {(DW+1){1'b0}};
      den_r <= {DW{1'b0}};
      cnt_r <= 6'h00;
      busy_r <= 1'b0;
      quotient <= {NW{1'b0}};
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy_r) begin
        num_r <= dividend;
        rem_r <= {(DW+1){1'b0}};
        den_r <= divisor;
        cnt_r <= NW[5:0];
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (!diff[DW]) begin
          rem_r <= diff;
          num_r <= {num_r[NW-2:0], 1'b1};
        end else begin
          rem_r <= shifted;
          num_r <= {num_r[NW-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          busy_r <= 1'b0;
          done <= 1'b1;
          quotient <= {num_r[NW-2:0], ~diff[DW]};
        end
      end
    end
  end

endmodule

// *** src/fan_speed_monitor_alarm.v ***
// Fan speed measurement, tach, alarm and start ramp logic
`timescale 1ns/1ps
`include "fan_monitor_defines.vh"

module fan_speed_monitor_alarm #(
  parameter [`PERIOD_W-1:0] START_DELAY = `START_DELAY_DEF,
  parameter [`SPEED_W-1:0] RAMP_STEP = `RAMP_STEP_DEF,
  parameter [`PERIOD_W-1:0] RAMP_INTERVAL = `RAMP_INTERVAL_DEF,
  parameter [`QUOT_W-1:0] SPEED_K = `SPEED_K
) (
  input wire clk,
  input wire rst,
  input wire pwm_tick,
  input wire hall_in,
  input wire bridge_aux_out_a,
  input wire tach_sel,
  input wire [`SPEED_W-1:0] speed_cmd,
  input wire [`PERIOD_W-1:0] lock_max,
  input wire [7:0] alarm_max,
  output reg [`SPEED_W-1:0] speed_val,
  output reg speed_new,
  output reg meas_invalid,
  output reg locked,
  output reg tach_out,
  output reg alarm_out,
  output reg [`SPEED_W-1:0] drive_speed,
  output reg starting
);

  // Hall synchroniser and edge detect
  reg hall_s1_r;
  reg hall_s2_r;
  reg hall_d_r;
  wire hall_rise;

  always @(posedge clk) begin
    if (rst) begin
      hall_s1_r <= 1'b0;
      hall_s2_r <= 1'b0;
      hall_d_r <= 1'b0;
    end else begin
      hall_s1_r <= hall_in;
      hall_s2_r <= hall_s1_r;
      hall_d_r <= hall_s2_r;
    end
  end

  assign hall_rise = hall_s2_r & ~hall_d_r;

  // Period counter on PWM ticks
  reg [`PERIOD_W-1:0] period_cnt_r;
  reg [`PERIOD_W-1:0] period_r;
  reg div_start_r;
  reg locked_nxt;
  reg seen_r;

  always @* begin
    locked_nxt = locked;
    if (hall_rise)
      locked_nxt = 1'b0;
    else if (period_cnt_r > lock_max)
      locked_nxt = 1'b1;
  end

  always @(posedge clk) begin
    if (rst) begin
      period_cnt_r <= {`PERIOD_W{1'b0}};
      period_r <= {`PERIOD_W{1'b0}};
      div_start_r <= 1'b0;
      locked <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      div_start_r <= 1'b0;
      locked <= locked_nxt;
      if (hall_rise) begin
        // Zero period would divide by zero
        if (period_cnt_r == {`PERIOD_W{1'b0}})
          period_r <= {{(`PERIOD_W-1){1'b0}}, 1'b1};
        else
          period_r <= period_cnt_r;
        // First edge after reset only opens the count
        div_start_r <= ~locked & seen_r;
        seen_r <= 1'b1;
        if (pwm_tick)
          period_cnt_r <= {{(`PERIOD_W-1){1'b0}}, 1'b1};
        else
          period_cnt_r <= {`PERIOD_W{1'b0}};
      end else if (pwm_tick && (period_cnt_r <= lock_max)) begin
        period_cnt_r <= period_cnt_r + 1'b1;
      end
    end
  end

  // Speed conversion: constant divided by period
  wire [`QUOT_W-1:0] quot;
  wire div_done;

  speed_divider #(
    .NW(`QUOT_W),
    .DW(`PERIOD_W)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .start(div_start_r),
    .dividend(SPEED_K),
    .divisor(period_r),
    .quotient(quot),
    .done(div_done)
  );

  wire over_range;
  assign over_range = |quot[`QUOT_W-1:`SPEED_W];

  always @(posedge clk) begin
    if (rst) begin
      speed_val <= {`SPEED_W{1'b0}};
      meas_invalid <= 1'b0;
      speed_new <= 1'b0;
    end else begin
      speed_new <= div_done;
      if (locked_nxt && !locked) begin
        speed_val <= {`SPEED_W{1'b0}};
        meas_invalid <= 1'b0;
      end else if (div_done) begin
        meas_invalid <= over_range;
        if (over_range)
          speed_val <= {`SPEED_W{1'b1}};
        else
          speed_val <= quot[`SPEED_W-1:0];
      end
    end
  end

  // Tachometer output
  always @(posedge clk) begin
    if (rst) begin
      tach_out <= 1'b1;
    end else if (tach_sel) begin
      tach_out <= bridge_aux_out_a;
    end else if (locked) begin
      tach_out <= 1'b1;
    end else begin
      tach_out <= hall_s2_r;
    end
  end

  // Alarm threshold and counter
  wire [15:0] thr_prod;
  wire [15:0] thr_full;
  wire [`SPEED_W-1:0] alarm_thr;
  reg [7:0] alarm_cnt_r;
  reg alarm_eval_r;

  assign thr_prod = speed_cmd * `ALARM_PCT;
  assign thr_full = thr_prod / `PCT_FULL;
  assign alarm_thr = thr_full[`SPEED_W-1:0];

  always @(posedge clk) begin
    if (rst) begin
      alarm_eval_r <= 1'b0;
    end else begin
      alarm_eval_r <= div_done;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      alarm_cnt_r <= 8'h00;
      alarm_out <= 1'b0;
    end else if (locked) begin
      alarm_out <= 1'b1;
    end else if (alarm_eval_r) begin
      if (speed_val < alarm_thr) begin
        if (alarm_cnt_r != 8'hff)
          alarm_cnt_r <= alarm_cnt_r + 8'h01;
        if (alarm_cnt_r >= alarm_max)
          alarm_out <= 1'b1;
      end else begin
        alarm_cnt_r <= 8'h00;
        alarm_out <= 1'b0;
      end
    end
  end

  // Start delay and ramp
  localparam [1:0] S_IDLE = `ST_IDLE;
  localparam [1:0] S_DELAY = `ST_DELAY;
  localparam [1:0] S_RAMP = `ST_RAMP;
  localparam [1:0] S_RUN = `ST_RUN;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`PERIOD_W-1:0] tick_cnt_r;
  reg [`PERIOD_W-1:0] tick_cnt_nxt;
  reg [`SPEED_W-1:0] drive_nxt;
  wire [`SPEED_W:0] ramp_sum;

  assign ramp_sum = {1'b0, drive_speed} + {1'b0, RAMP_STEP};

  always @* begin
    state_nxt = state_r;
    tick_cnt_nxt = tick_cnt_r;
    drive_nxt = drive_speed;
    if (speed_cmd == {`SPEED_W{1'b0}}) begin
      state_nxt = S_IDLE;
      tick_cnt_nxt = {`PERIOD_W{1'b0}};
      drive_nxt = {`SPEED_W{1'b0}};
    end else begin
      case (state_r)
        S_IDLE: begin
          state_nxt = S_DELAY;
          tick_cnt_nxt = {`PERIOD_W{1'b0}};
          drive_nxt = {`SPEED_W{1'b0}};
        end
        S_DELAY: begin
          drive_nxt = {`SPEED_W{1'b0}};
          if (pwm_tick) begin
            if (tick_cnt_r >= START_DELAY - 1'b1) begin
              state_nxt = S_RAMP;
              tick_cnt_nxt = {`PERIOD_W{1'b0}};
            end else begin
              tick_cnt_nxt = tick_cnt_r + 1'b1;
            end
          end
        end
        S_RAMP: begin
          if (pwm_tick) begin
            if (tick_cnt_r >= RAMP_INTERVAL - 1'b1) begin
              tick_cnt_nxt = {`PERIOD_W{1'b0}};
              if (ramp_sum >= {1'b0, speed_cmd}) begin
                drive_nxt = speed_cmd;
                state_nxt = S_RUN;
              end else begin
                drive_nxt = ramp_sum[`SPEED_W-1:0];
              end
            end else begin
              tick_cnt_nxt = tick_cnt_r + 1'b1;
            end
          end
        end
        S_RUN: begin
          drive_nxt = speed_cmd;
        end
        default: begin
          state_nxt = S_IDLE;
          tick_cnt_nxt = {`PERIOD_W{1'b0}};
          drive_nxt = {`SPEED_W{1'b0}};
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r <= S_DELAY;
      tick_cnt_r <= {`PERIOD_W{1'b0}};
      drive_speed <= {`SPEED_W{1'b0}};
      starting <= 1'b1;
    end else begin
      state_r <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      drive_speed <= drive_nxt;
      starting <= (state_nxt == S_DELAY) || (state_nxt == S_RAMP);
    end
  end

endmodule

// *** verification/hall_sensor_model.sv ***
// Hall sensor model that toggles every half_ticks PWM ticks while running
`timescale 1ns/1ps
module hall_sensor_model (
  input logic clk,
  input logic pwm_tick,
  input logic run,
  input logic [15:0] half_ticks,
  output logic hall_out
);
  logic [15:0] cnt_r = 16'h0000;
  initial hall_out = 1'b0;
  // Stopped rotor holds its last level
  always @(posedge clk) begin
    if (pwm_tick && run) begin
      if (cnt_r + 16'h0001 >= half_ticks) begin
        cnt_r <= 16'h0000;
        hall_out <= ~hall_out;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule

// *** verification/fan_speed_monitor_alarm_checker.sv ***
// Assertion checker for the fan speed monitor and alarm block
`timescale 1ns/1ps
module fan_speed_monitor_alarm_checker (
  input logic clk,
  input logic rst,
  input logic tach_sel,
  input logic bridge_aux_out_a,
  input logic [7:0] speed_cmd,
  input logic [7:0] speed_val,
  input logic speed_new,
  input logic meas_invalid,
  input logic locked,
  input logic tach_out,
  input logic alarm_out,
  input logic [7:0] drive_speed,
  input logic starting
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_delay_hold;
    drive_speed == 8'h00 [*8];
  endsequence
  sequence s_tach_steady;
    tach_sel ##1 tach_sel;
  endsequence
  a_new_pulse_spacing: assert property (speed_new |=> !speed_new [*8])
    else $error("speed_new pulses too close");
  a_invalid_saturates: assert property (
    speed_new && meas_invalid |-> speed_val == 8'hff)
    else $error("invalid speed not saturated");
  a_speed_holds: assert property (!speed_new && !locked |-> $stable(speed_val))
    else $error("speed_val changed without measurement");
  a_lock_alarm: assert property (locked |=> alarm_out)
    else $error("alarm not raised while locked");
  a_lock_tach_high: assert property (
    (locked && !tach_sel) ##1 (locked && !tach_sel) |-> tach_out)
    else $error("tach not held high while locked");
  a_tach_follows_aux: assert property (
    s_tach_steady |-> tach_out == $past(bridge_aux_out_a))
    else $error("tach does not follow aux bridge output");
  a_zero_cmd_stop: assert property (
    speed_cmd == 8'h00 |=> drive_speed == 8'h00)
    else $error("drive not stopped on zero command");
  a_start_delay_hold: assert property ($rose(starting) |-> s_delay_hold)
    else $error("drive applied during start delay");
  a_run_follows: assert property (
    !starting && drive_speed != 8'h00 && speed_cmd != 8'h00
    |=> drive_speed == $past(speed_cmd))
    else $error("running drive does not follow command");
endmodule

bind fan_speed_monitor_alarm fan_speed_monitor_alarm_checker chk (
  .clk(clk), .rst(rst), .tach_sel(tach_sel),
  .bridge_aux_out_a(bridge_aux_out_a), .speed_cmd(speed_cmd),
  .speed_val(speed_val), .speed_new(speed_new),
  .meas_invalid(meas_invalid), .locked(locked), .tach_out(tach_out),
  .alarm_out(alarm_out), .drive_speed(drive_speed), .starting(starting)
);

// *** verification/fan_speed_monitor_alarm_bench.sv ***
// Self-checking bench for the fan speed monitor and alarm block
`timescale 1ns/1ps
`include "fan_monitor_defines.vh"
module fan_speed_monitor_alarm_bench;
  logic clk = 0, rst = 1, pwm_tick = 0, bridge_aux_out_a = 0;
  logic tach_sel = 0, run = 0;
  logic [7:0] speed_cmd = 8'hff, alarm_max = 8'h01;
  logic [15:0] lock_max = 16'h0800, half = 16'h0080;
  logic hall, speed_new, meas_invalid, locked, tach_out, alarm_out, starting;
  logic [7:0] speed_val, drive_speed;
  int mismatches = 0, total_checks = 0, exp_q, n;
  // Half period in ticks, commanded speed
  int rows [6][2] = '{'{128, 255}, '{114, 255}, '{100, 255},
    '{500, 90}, '{500, 88}, '{500, 89}};

  always #4 clk = ~clk;
  always @(posedge clk) pwm_tick <= #1 ~pwm_tick;

  fan_speed_monitor_alarm #(.START_DELAY(16'h0004), .RAMP_STEP(8'h04),
    .RAMP_INTERVAL(16'h0002)) dut (.clk(clk), .rst(rst),
    .pwm_tick(pwm_tick), .hall_in(hall),
    .bridge_aux_out_a(bridge_aux_out_a), .tach_sel(tach_sel),
    .speed_cmd(speed_cmd), .lock_max(lock_max), .alarm_max(alarm_max),
    .speed_val(speed_val), .speed_new(speed_new),
    .meas_invalid(meas_invalid), .locked(locked), .tach_out(tach_out),
    .alarm_out(alarm_out), .drive_speed(drive_speed), .starting(starting));
  hall_sensor_model hall_m (.clk(clk), .pwm_tick(pwm_tick), .run(run),
    .half_ticks(half), .hall_out(hall));

  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_new(input int cnt);
    repeat (cnt) begin
      @(negedge clk);
      for (int i = 0; i < 5000 && speed_new !== 1'b1; i++) @(negedge clk);
      check("speed_new", speed_new, 1);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(8 * 80000);
    mismatches++;
    close_out;
  end

  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    run = 1;
    foreach (rows[r]) begin
      @(posedge clk);
      #1 half = rows[r][0];
      speed_cmd = rows[r][1];
      wait_new(3);
      exp_q = `SPEED_K / (2 * half);
      check("meas_invalid", meas_invalid, exp_q > 255);
      check("speed_val", speed_val, exp_q > 255 ? 255 : exp_q);
      repeat (3) @(negedge clk);
      check("alarm_out", alarm_out, exp_q < speed_cmd * 65 / 100);
      $display("row %0d done", r);
    end
    wait (hall === 1'b0);
    @(posedge clk);
    #1 run = 0;
    n = 0;
    while (locked !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    check("lock_time", n > 2000 && n < 4200, 1);
    @(negedge clk);
    check("tach_locked", tach_out, 1);
    check("alarm_locked", alarm_out, 1);
    @(posedge clk);
    #1 run = 1;
    half = 16'h0080;
    n = 0;
    while (locked !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check("lock_clear", locked, 0);
    $display("lock test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1 tach_sel = 1;
      bridge_aux_out_a = i[0];
      repeat (2) @(negedge clk);
      check("tach_aux", tach_out, i[0]);
    end
    $display("tach test done");
    @(posedge clk);
    #1 rst = 1;
    tach_sel = 0;
    speed_cmd = 8'h0a;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("reset_state", {speed_val, tach_out, alarm_out, starting},
      11'h005);
    @(posedge clk);
    #1 rst = 0;
    repeat (4) @(negedge clk);
    check("delay_drive", drive_speed, 0);
    for (n = 0; drive_speed === 8'h00 && n < 200; n++) @(negedge clk);
    check("first_step", drive_speed, 8'h04);
    for (n = 0; starting !== 1'b0 && n < 200; n++) @(negedge clk);
    check("ramp_end", drive_speed, 8'h0a);
    @(posedge clk);
    #1 speed_cmd = 8'h00;
    @(posedge clk);
    #1 speed_cmd = 8'h0a;
    repeat (2) @(negedge clk);
    check("restart", {drive_speed, starting}, 9'h001);
    for (n = 0; starting !== 1'b0 && n < 200; n++) @(negedge clk);
    check("restart_end", drive_speed, 8'h0a);
    $display("start test done");
    close_out;
  end
endmodule
